//--- shc_consts.vh
// constants of the sensor hub with magnetometer iron correction
`ifndef SHC_CONSTS_VH
`define SHC_CONSTS_VH
`define SHC_CLK_HZ        100000000
`define SHC_SCL_HZ        400000
`define SHC_MCFG_MASTER   0
`define SHC_MCFG_IRON     1
`define SHC_MCFG_PASS     2
`define SHC_MCFG_PULLUP   3
`define SHC_CT10_FUNC     2
`define SHC_CT9_SOFT      2
`define SHC_BANK_SEL      7
`define SHC_EMB_S0_ADDR   5'h02
`define SHC_EMB_S0_REG    5'h03
`define SHC_EMB_S0_CFG    5'h04
`define SHC_EMB_S0_WD     5'h0E
`define SHC_EMB_OFF_BASE  5'h10
`define SHC_OFF_COUNT     6
`define SHC_RES_COUNT     18
`define SHC_RES_COUNT_IDX 5'd18
`define SHC_UNCAL_BASE    12
`define SHC_MAG_NUMOP     3'd6
`define SHC_ACK_BIT       4'd8
`define SHC_PH_DRIVE      2'd0
`define SHC_PH_RISE       2'd1
`define SHC_PH_SAMPLE     2'd2
`define SHC_PH_FALL       2'd3
`define SHC_BYTE_RST      8'h00
`endif

//--- shc_sensor_hub.v
// sensor hub slot 0 auxiliary i2c master with hard-iron correction
//
// Behaviour
// - passthrough bit hands the auxiliary lines directly to the host lines.
// - master enable bit turns on the hub, polling the external sensor.
// - ironing functions work only while embedded function enable is set.
// - mode: none, hard-iron only, or hard plus soft from two bits.
// - hard plus soft gives calibrated and uncalibrated (raw, no correction) data.
// - each axis offset is 16-bit two's complement in low/high bytes.
// - offset registers reachable only while embedded bank access is set.
// - hard-iron correction runs only with function and iron enables set.
// - slot 0 address holds 7-bit target in bits 7..1, bit 0 direction.
// - slot 0 write sends write data to the named target register.
// - access byte 80h exposes embedded bank, 00h returns normal bank.
// - slot 0 setup 06h means no decimation, one sensor, six reads.
// - master value 09h: pull-ups on, accel trigger, master on.
// - six reads from 28h land in result registers 1 to 6.
// - 3Ch to control ten enables embedded functions, 38h disables.
// - enabled slot transfer runs at the next hub trigger event.
// - read bytes stored in order from the first of 18 results.
`timescale 1ns/1ps
`include "shc_consts.vh"
module shc_sensor_hub #(
    parameter integer QN = `SHC_CLK_HZ / (4 * `SHC_SCL_HZ)
) (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // host configuration levels
    input  wire [7:0] master_cfg,
    input  wire [7:0] control_ten,
    input  wire [7:0] control_nine,
    input  wire [7:0] bank_access,
    // embedded bank writes
    input  wire       emb_wr,
    input  wire [4:0] emb_idx,
    input  wire [7:0] emb_wdata,
    // result read
    input  wire [4:0] res_idx,
    output reg  [7:0] res_rdata_q,
    // hub trigger from accelerometer
    input  wire       accel_drdy,
    // status
    output wire       hub_busy,
    output reg        hub_done_q,
    output reg        nack_err_q,
    output reg        aux_pullup_en_q,
    // auxiliary i2c pins
    output wire       aux_scl_o,
    output reg        aux_scl_oe_n_q,
    input  wire       aux_sda_i,
    output wire       aux_sda_o,
    output reg        aux_sda_oe_n_q,
    // passthrough host pins
    input  wire       pt_scl_i,
    input  wire       pt_sda_i,
    output reg        pt_sda_o_q
);
    localparam [7:0] Q_LAST   = QN[7:0] - 8'h01;
    localparam [2:0] S_IDLE   = 3'd0;
    localparam [2:0] S_START  = 3'd1;
    localparam [2:0] S_BYTE   = 3'd2;
    localparam [2:0] S_RSTART = 3'd3;
    localparam [2:0] S_STOP   = 3'd4;
    localparam [2:0] S_CORR   = 3'd5;
    localparam [2:0] Q_AW     = 3'd0;
    localparam [2:0] Q_REG    = 3'd1;
    localparam [2:0] Q_WD     = 3'd2;
    localparam [2:0] Q_AR     = 3'd3;
    localparam [2:0] Q_RX     = 3'd4;

    function [2:0] dec_mask;
        input [1:0] rate;
        begin
            case (rate)
                2'd0:    dec_mask = 3'b000;
                2'd1:    dec_mask = 3'b001;
                2'd2:    dec_mask = 3'b011;
                default: dec_mask = 3'b111;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers: {pt_scl, pt_sda, aux_sda}
    // ------------------------------------------------------------------
    reg  [2:0] sy1_q;
    reg  [2:0] sy2_q;
    reg  [2:0] sy3_q;
    reg  [2:0] pin_q;
    always @(posedge core_clk) begin
        if (rst) begin
            sy1_q <= 3'h7;
            sy2_q <= 3'h7;
            sy3_q <= 3'h7;
            pin_q <= 3'h7;
        end else begin
            sy1_q <= {pt_scl_i, pt_sda_i, aux_sda_i};
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            pin_q <= (sy2_q & sy3_q) | (pin_q & (sy2_q ^ sy3_q));
        end
    end
    wire sda_f = pin_q[0];

    // ------------------------------------------------------------------
    // embedded bank registers
    // ------------------------------------------------------------------
    reg  [7:0] s0_addr_q;
    reg  [7:0] s0_reg_q;
    reg  [7:0] s0_cfg_q;
    reg  [7:0] s0_wd_q;
    reg  [7:0] off_q [0:`SHC_OFF_COUNT-1];
    wire       bank_sel = bank_access[`SHC_BANK_SEL];
    integer    i;
    integer    j;
    always @(posedge core_clk) begin
        if (rst) begin
            s0_addr_q <= `SHC_BYTE_RST;
            s0_reg_q  <= `SHC_BYTE_RST;
            s0_cfg_q  <= `SHC_BYTE_RST;
            s0_wd_q   <= `SHC_BYTE_RST;
            for (i = 0; i < `SHC_OFF_COUNT; i = i + 1)
                off_q[i] <= `SHC_BYTE_RST;
        end else if (emb_wr && bank_sel) begin
            case (emb_idx)
                `SHC_EMB_S0_ADDR: s0_addr_q <= emb_wdata;
                `SHC_EMB_S0_REG:  s0_reg_q  <= emb_wdata;
                `SHC_EMB_S0_CFG:  s0_cfg_q  <= emb_wdata;
                `SHC_EMB_S0_WD:   s0_wd_q   <= emb_wdata;
                default: begin
                    for (i = 0; i < `SHC_OFF_COUNT; i = i + 1)
                        if (emb_idx == `SHC_EMB_OFF_BASE + i[4:0])
                            off_q[i] <= emb_wdata;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire       pass     = master_cfg[`SHC_MCFG_PASS];
    wire       hub_on   = master_cfg[`SHC_MCFG_MASTER] & ~pass;
    wire       embedded_func_enable  = control_ten[`SHC_CT10_FUNC];
    wire       iron_en  = master_cfg[`SHC_MCFG_IRON];
    wire       soft_en  = control_nine[`SHC_CT9_SOFT];
    wire [2:0] numop    = s0_cfg_q[2:0];
    wire       do_hard  = embedded_func_enable & iron_en
                        & (numop == `SHC_MAG_NUMOP);
    wire       do_soft  = do_hard & soft_en;

    // ------------------------------------------------------------------
    // trigger and decimation
    // ------------------------------------------------------------------
    reg        drdy_q;
    reg  [2:0] dec_q;
    reg  [2:0] st_q;
    wire       trig     = accel_drdy & ~drdy_q;
    wire       dec_ok   = (dec_q & dec_mask(s0_cfg_q[7:6])) == 3'd0;
    wire       start_go = trig & hub_on & dec_ok & (st_q == S_IDLE);
    always @(posedge core_clk) begin
        if (rst) begin
            drdy_q <= 1'b0;
            dec_q  <= 3'd0;
        end else begin
            drdy_q <= accel_drdy;
            if (!hub_on)
                dec_q <= 3'd0;
            else if (trig)
                dec_q <= dec_q + 3'd1;
        end
    end

    // ------------------------------------------------------------------
    // i2c engine
    // ------------------------------------------------------------------
    reg  [7:0] qcnt_q;
    reg  [1:0] ph_q;
    reg  [3:0] bit_q;
    reg  [2:0] seq_q;
    reg  [7:0] tx_q;
    reg  [7:0] rx_q;
    reg  [2:0] rem_q;
    reg  [4:0] ptr_q;
    reg        rd_q;
    reg        nack_q;
    reg        scl_low_q;
    reg        sda_low_q;
    wire       tick   = (qcnt_q == Q_LAST);
    wire       txing  = (seq_q != Q_RX);
    wire       b_end  = (st_q == S_BYTE) && tick && (ph_q == `SHC_PH_FALL)
                     && (bit_q == `SHC_ACK_BIT);
    wire       store  = b_end && !txing;
    assign hub_busy = (st_q != S_IDLE);

    always @(posedge core_clk) begin
        if (rst) begin
            st_q <= S_IDLE;
            qcnt_q <= 8'h00;
            ph_q <= 2'd0;
            bit_q <= 4'd0;
            seq_q <= Q_AW;
            tx_q <= `SHC_BYTE_RST;
            rx_q <= `SHC_BYTE_RST;
            rem_q <= 3'd0;
            ptr_q <= 5'd0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            hub_done_q <= 1'b0;
            nack_err_q <= 1'b0;
        end else begin
            hub_done_q <= 1'b0;
            nack_err_q <= 1'b0;
            qcnt_q <= (tick || st_q == S_IDLE) ? 8'h00 : qcnt_q + 8'h01;
            if (tick)
                ph_q <= ph_q + 2'd1;
            if (!hub_on) begin
                st_q <= S_IDLE;
                scl_low_q <= 1'b0;
                sda_low_q <= 1'b0;
            end else case (st_q)
                S_IDLE: begin
                    ph_q <= `SHC_PH_DRIVE;
                    if (start_go) begin
                        st_q  <= S_START;
                        rd_q  <= s0_addr_q[0];
                        tx_q  <= {s0_addr_q[7:1], 1'b0};
                        seq_q <= Q_AW;
                        rem_q <= numop;
                        ptr_q <= 5'd0;
                    end
                end
                S_START: if (tick) begin
                    if (ph_q == `SHC_PH_SAMPLE)
                        sda_low_q <= 1'b1;
                    if (ph_q == `SHC_PH_FALL) begin
                        scl_low_q <= 1'b1;
                        bit_q <= 4'd0;
                        st_q <= S_BYTE;
                    end
                end
                S_BYTE: if (tick) begin
                    case (ph_q)
                        `SHC_PH_DRIVE: begin
                            if (bit_q != `SHC_ACK_BIT)
                                sda_low_q <= txing & ~tx_q[7];
                            else
                                sda_low_q <= ~txing & (rem_q != 3'd1);
                        end
                        `SHC_PH_RISE: scl_low_q <= 1'b0;
                        `SHC_PH_SAMPLE: begin
                            if (bit_q != `SHC_ACK_BIT) begin
                                rx_q <= {rx_q[6:0], sda_f};
                                tx_q <= {tx_q[6:0], 1'b0};
                            end else
                                nack_q <= sda_f;
                        end
                        default: begin
                            scl_low_q <= 1'b1;
                            bit_q <= bit_q + 4'd1;
                        end
                    endcase
                    if (b_end) begin
                        bit_q <= 4'd0;
                        if (txing && nack_q) begin
                            nack_err_q <= 1'b1;
                            rd_q <= 1'b0;
                            st_q <= S_STOP;
                        end else case (seq_q)
                            Q_AW: begin
                                seq_q <= Q_REG;
                                tx_q <= s0_reg_q;
                            end
                            Q_REG: begin
                                if (!rd_q) begin
                                    seq_q <= Q_WD;
                                    tx_q <= s0_wd_q;
                                end else if (rem_q == 3'd0)
                                    st_q <= S_STOP;
                                else
                                    st_q <= S_RSTART;
                            end
                            Q_AR: seq_q <= Q_RX;
                            Q_RX: begin
                                ptr_q <= ptr_q + 5'd1;
                                rem_q <= rem_q - 3'd1;
                                if (rem_q == 3'd1)
                                    st_q <= S_STOP;
                            end
                            default: st_q <= S_STOP;
                        endcase
                    end
                end
                S_RSTART: if (tick) begin
                    case (ph_q)
                        `SHC_PH_DRIVE:  sda_low_q <= 1'b0;
                        `SHC_PH_RISE:   scl_low_q <= 1'b0;
                        `SHC_PH_SAMPLE: sda_low_q <= 1'b1;
                        default: begin
                            scl_low_q <= 1'b1;
                            seq_q <= Q_AR;
                            tx_q <= {s0_addr_q[7:1], 1'b1};
                            st_q <= S_BYTE;
                        end
                    endcase
                end
                S_STOP: if (tick) begin
                    case (ph_q)
                        `SHC_PH_DRIVE:  sda_low_q <= 1'b1;
                        `SHC_PH_RISE:   scl_low_q <= 1'b0;
                        `SHC_PH_SAMPLE: sda_low_q <= 1'b0;
                        default: begin
                            st_q <= rd_q ? S_CORR : S_IDLE;
                            hub_done_q <= ~rd_q;
                        end
                    endcase
                end
                S_CORR: begin
                    st_q <= S_IDLE;
                    hub_done_q <= 1'b1;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // result registers and correction
    // ------------------------------------------------------------------
    reg  [7:0]  res_q [0:`SHC_RES_COUNT-1];
    wire [47:0] raw_all;
    wire [47:0] cal_all;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : axis
            wire [15:0] raw = {res_q[2*g+1], res_q[2*g]};
            wire [15:0] off = {off_q[2*g+1], off_q[2*g]};
            assign raw_all[16*g +: 16] = raw;
            assign cal_all[16*g +: 16] = raw - off;
        end
    endgenerate

    always @(posedge core_clk) begin
        if (rst) begin
            for (j = 0; j < `SHC_RES_COUNT; j = j + 1)
                res_q[j] <= `SHC_BYTE_RST;
        end else if (store) begin
            res_q[ptr_q] <= rx_q;
        end else if (st_q == S_CORR && do_hard) begin
            for (j = 0; j < `SHC_OFF_COUNT; j = j + 1) begin
                res_q[j] <= cal_all[8*j +: 8];
                if (do_soft)
                    res_q[`SHC_UNCAL_BASE + j] <= raw_all[8*j +: 8];
            end
        end
    end

    // ------------------------------------------------------------------
    // host read and pin drive
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            res_rdata_q <= `SHC_BYTE_RST;
            aux_pullup_en_q <= 1'b0;
            aux_scl_oe_n_q <= 1'b1;
            aux_sda_oe_n_q <= 1'b1;
            pt_sda_o_q <= 1'b1;
        end else begin
            if (!bank_sel && res_idx < `SHC_RES_COUNT_IDX)
                res_rdata_q <= res_q[res_idx];
            else
                res_rdata_q <= `SHC_BYTE_RST;
            aux_pullup_en_q <= master_cfg[`SHC_MCFG_PULLUP];
            aux_scl_oe_n_q <= pass ? pin_q[2] : ~scl_low_q;
            aux_sda_oe_n_q <= pass ? pin_q[1] : ~sda_low_q;
            pt_sda_o_q <= pass ? sda_f : 1'b1;
        end
    end
    assign aux_scl_o = 1'b0;
    assign aux_sda_o = 1'b0;
endmodule

//--- shc_mag_model.sv
// behavioural magnetometer target on the auxiliary bus
`timescale 1ns/1ps
module shc_mag_model #(
    parameter logic [6:0] ADDR = 7'h1C
) (
    // bus wires
    input  wire logic scl,
    input  wire logic sda,
    // pulls the data wire low
    output logic      sda_low
);
    logic [7:0] mem [0:255];
    logic [7:0] sh, ob, ptr, ab;
    logic       act, tx, sel, mack;
    int         bc, nb;
    initial begin
        act = 1'b0;
        sda_low = 1'b0;
        ptr = 8'h00;
        ob = 8'hFF;
    end
    // start or repeated start, pointer is kept
    always @(negedge sda) if (scl === 1'b1) begin
        act = 1'b1;
        bc = 0;
        nb = 0;
        tx = 1'b0;
        sel = 1'b0;
        sda_low = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        act = 1'b0;
        sda_low = 1'b0;
    end
    always @(posedge scl) if (act) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else mack = !sda;
        bc = bc + 1;
    end
    always @(negedge scl) if (act) begin
        if (bc == 9) begin
            bc = 0;
            if (nb == 0) begin
                ab = sh;
                tx = sh[0];
                sel = (sh[7:1] == ADDR);
            end else if (sel && !tx && nb == 1) ptr = sh;
            else if (sel && !tx) begin
                mem[ptr] = sh;
                ptr = ptr + 8'h01;
            end
            nb = nb + 1;
            ob = 8'hFF;
            // next byte only after an acknowledge, else let go
            if (tx && sel && (nb == 1 || mack)) begin
                ob = mem[ptr];
                ptr = ptr + 8'h01;
            end
        end
        if (bc == 8) sda_low = (nb == 0) ? (sh[7:1] == ADDR) : (sel && !tx);
        else sda_low = sel && tx && !ob[7-bc];
    end
endmodule

//--- shc_hub_chk.sv
// port assertions for the sensor hub
`timescale 1ns/1ps
module shc_hub_chk #(
    parameter integer QN = 62
) (
    // clock and reset
    input wire       core_clk,
    input wire       rst,
    // host side
    input wire [7:0] master_cfg,
    input wire [7:0] bank_access,
    input wire [4:0] res_idx,
    input wire [7:0] res_rdata_q,
    input wire       accel_drdy,
    // status and pins
    input wire       hub_busy,
    input wire       hub_done_q,
    input wire       nack_err_q,
    input wire       aux_pullup_en_q,
    input wire       aux_scl_oe_n_q,
    input wire       aux_sda_oe_n_q,
    input wire       pt_sda_o_q
);
    localparam int LIM = 400 * QN + 64;
    int busy_cnt;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // cycles spent busy in one hub cycle
    always @(posedge core_clk) begin
        if (rst || !hub_busy) busy_cnt <= 0;
        else busy_cnt <= busy_cnt + 1;
    end
    sequence calm_s;
        (!hub_busy && !master_cfg[2]) [*3];
    endsequence
    sequence trig_s;
        !accel_drdy ##1 accel_drdy;
    endsequence
    pass_hold_a: assert property (master_cfg[2] |=> !hub_busy)
        else $error("hub ran in passthrough");
    pass_sda_a: assert property (
        !master_cfg[2] && !$past(master_cfg[2]) |-> pt_sda_o_q)
        else $error("host data not idle");
    hub_off_a: assert property (!master_cfg[0] |=> !hub_busy)
        else $error("hub busy while off");
    no_trig_a: assert property (
        !hub_busy && !$rose(accel_drdy) |=> !hub_busy)
        else $error("hub started without trigger");
    lines_free_a: assert property (
        calm_s |-> aux_scl_oe_n_q && aux_sda_oe_n_q)
        else $error("aux lines held while idle");
    done_once_a: assert property (hub_done_q |=> !hub_done_q)
        else $error("done longer than one cycle");
    nack_end_a: assert property (nack_err_q |-> ##[1:1000] hub_done_q)
        else $error("no done after nack");
    busy_bound_a: assert property (busy_cnt <= LIM)
        else $error("hub cycle too long");
    res_hidden_a: assert property (
        bank_access[7] |=> res_rdata_q == 8'h00)
        else $error("result seen in embedded bank");
    res_range_a: assert property (
        res_idx > 5'd17 |=> res_rdata_q == 8'h00)
        else $error("result beyond eighteen");
    pullup_cfg_a: assert property (
        $changed(master_cfg[3]) |=> aux_pullup_en_q == $past(master_cfg[3]))
        else $error("pull-up enable wrong");
    trig_run_c: cover property (trig_s ##1 hub_busy);
endmodule
bind shc_sensor_hub shc_hub_chk #(.QN(QN)) chk (
    .core_clk, .rst, .master_cfg, .bank_access, .res_idx, .res_rdata_q,
    .accel_drdy, .hub_busy, .hub_done_q, .nack_err_q, .aux_pullup_en_q,
    .aux_scl_oe_n_q, .aux_sda_oe_n_q, .pt_sda_o_q
);

//--- tb_top.sv
// self-checking bench for the sensor hub
`timescale 1ns/1ps
module tb_top;
    logic        core_clk, rst, emb_wr, accel_drdy, pt_scl_i, pt_sda_i;
    logic        hub_busy, hub_done_q, nack_err_q, aux_pullup_en_q;
    logic        aux_scl_o, aux_scl_oe_n_q, aux_sda_o, aux_sda_oe_n_q;
    logic        pt_sda_o_q, sda_low, nack_seen, pt_run;
    logic [7:0]  master_cfg, control_ten, control_nine, bank_access;
    logic [7:0]  emb_wdata, res_rdata_q, v;
    logic [4:0]  emb_idx, res_idx;
    logic [15:0] raw [0:2];
    logic [15:0] off [0:2];
    int          err_count, checks;
    wire         sda_w = (aux_sda_oe_n_q | aux_sda_o) & ~sda_low;
    wire         scl_w = aux_scl_oe_n_q | aux_scl_o;
    shc_sensor_hub #(.QN(4)) dut (
        .core_clk(core_clk), .rst(rst), .master_cfg(master_cfg),
        .control_ten(control_ten), .control_nine(control_nine),
        .bank_access(bank_access), .emb_wr(emb_wr), .emb_idx(emb_idx),
        .emb_wdata(emb_wdata), .res_idx(res_idx), .res_rdata_q(res_rdata_q),
        .accel_drdy(accel_drdy), .hub_busy(hub_busy),
        .hub_done_q(hub_done_q), .nack_err_q(nack_err_q),
        .aux_pullup_en_q(aux_pullup_en_q), .aux_scl_o(aux_scl_o),
        .aux_scl_oe_n_q(aux_scl_oe_n_q), .aux_sda_i(sda_w),
        .aux_sda_o(aux_sda_o), .aux_sda_oe_n_q(aux_sda_oe_n_q),
        .pt_scl_i(pt_scl_i), .pt_sda_i(pt_sda_i), .pt_sda_o_q(pt_sda_o_q));
    shc_mag_model mdl (.scl(scl_w), .sda(sda_w), .sda_low(sda_low));
    always #5 core_clk = ~core_clk;
    // host link clock, only while passthrough runs
    initial begin
        #2;
        forever #62.5 if (pt_run) pt_scl_i = ~pt_scl_i;
    end
    task automatic complete_run;
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic emb(input logic [4:0] i, input logic [7:0] d);
        @(posedge core_clk);
        emb_wr <= 1'b1;
        emb_idx <= i;
        emb_wdata <= d;
        @(posedge core_clk);
        emb_wr <= 1'b0;
    endtask
    task automatic cfg(input logic [7:0] m, t, n, b);
        @(posedge core_clk);
        master_cfg <= m;
        control_ten <= t;
        control_nine <= n;
        bank_access <= b;
    endtask
    task automatic rd(input logic [4:0] i);
        @(posedge core_clk);
        res_idx <= i;
        repeat (2) @(posedge core_clk);
        v = res_rdata_q;
    endtask
    task automatic run_hub;
        int n;
        nack_seen = 1'b0;
        @(posedge core_clk);
        chk("busy", 8'h00, {7'h00, hub_busy});
        accel_drdy <= 1'b1;
        for (n = 0; n < 20000 && hub_done_q !== 1'b1; n++) begin
            @(posedge core_clk);
            if (nack_err_q === 1'b1) nack_seen = 1'b1;
        end
        accel_drdy <= 1'b0;
        if (n == 20000) begin
            err_count++;
            $display("[ERR] hub_done exp 1 got 0");
            complete_run;
        end
    endtask
    task automatic chk_axes(input logic [4:0] base, input logic hard);
        logic [15:0] w;
        for (int a = 0; a < 6; a++) begin
            w = hard ? raw[a/2] - off[a/2] : raw[a/2];
            rd(base + a[4:0]);
            chk("result", a[0] ? w[15:8] : w[7:0], v);
        end
    endtask
    task automatic t_write;
        cfg(8'h00, 8'h38, 8'h00, 8'h80);
        emb(5'h02, 8'h38);
        emb(5'h03, 8'h22);
        emb(5'h0E, 8'hA5);
        for (int i = 0; i < 6; i++)
            emb(5'h10 + i[4:0], off[i/2][8*(i%2) +: 8]);
        cfg(8'h00, 8'h38, 8'h00, 8'h00);
        emb(5'h10, 8'hFF);
        cfg(8'h09, 8'h3C, 8'h00, 8'h00);
        run_hub;
        chk("target", 8'hA5, mdl.mem[8'h22]);
        chk("addr", 8'h38, mdl.ab);
        chk("pullup", 8'h01, {7'h00, aux_pullup_en_q});
        cfg(8'h00, 8'h38, 8'h00, 8'h00);
    endtask
    task automatic t_read;
        logic [7:0] mc [0:4] = '{8'h0B, 8'h09, 8'h0B, 8'h09, 8'h0B};
        logic [7:0] ct [0:4] = '{8'h3C, 8'h3C, 8'h38, 8'h3C, 8'h3C};
        logic [7:0] c9 [0:4] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04};
        cfg(8'h00, 8'h38, 8'h00, 8'h80);
        emb(5'h02, 8'h39);
        emb(5'h03, 8'h28);
        emb(5'h04, 8'h06);
        for (int m = 0; m < 5; m++) begin
            cfg(mc[m], ct[m], c9[m], 8'h00);
            run_hub;
            chk_axes(5'd0, m == 0 || m == 4);
        end
        chk_axes(5'd12, 1'b0);
        chk("addr", 8'h39, mdl.ab);
        rd(5'd18);
        chk("beyond", 8'h00, v);
        cfg(8'h00, 8'h38, 8'h00, 8'h80);
        rd(5'd0);
        chk("hidden", 8'h00, v);
        emb(5'h02, 8'h3B);
        emb(5'h04, 8'h46);
        cfg(8'h09, 8'h3C, 8'h00, 8'h00);
        run_hub;
        chk("nack", 8'h01, {7'h00, nack_seen});
        // second trigger falls in the decimation gap
        @(posedge core_clk);
        accel_drdy <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("decim", 8'h00, {7'h00, hub_busy});
        accel_drdy <= 1'b0;
    endtask
    task automatic t_pass;
        int n;
        logic s;
        cfg(8'h05, 8'h38, 8'h00, 8'h00);
        pt_run = 1'b1;
        pt_sda_i <= 1'b0;
        accel_drdy <= 1'b1;
        n = 0;
        s = aux_scl_oe_n_q;
        repeat (64) begin
            @(posedge core_clk);
            if (aux_scl_oe_n_q !== s) n++;
            s = aux_scl_oe_n_q;
        end
        chk("pt_scl", 8'h01, {7'h00, n >= 4});
        chk("pt_sda", 8'h00, {7'h00, pt_sda_o_q});
        chk("aux_sda", 8'h00, {7'h00, aux_sda_oe_n_q});
        chk("busy", 8'h00, {7'h00, hub_busy});
        pt_run = 1'b0;
        pt_scl_i <= 1'b1;
        @(posedge core_clk);
        pt_sda_i <= 1'b1;
        accel_drdy <= 1'b0;
        // host pin to aux pin and back: two synchronisers deep
        repeat (12) @(posedge core_clk);
        chk("pt_sda", 8'h01, {7'h00, pt_sda_o_q});
        cfg(8'h00, 8'h38, 8'h00, 8'h00);
    endtask
    initial begin
        {core_clk, rst, emb_wr, accel_drdy, pt_run} = 5'b01000;
        {pt_scl_i, pt_sda_i} = 2'b11;
        {master_cfg, control_ten, control_nine, bank_access} = 32'h0;
        {emb_idx, res_idx, emb_wdata} = 18'h0;
        {err_count, checks} = 0;
        raw = '{16'h0120, 16'hFE00, 16'h7FF0};
        off = '{16'hF708, 16'h0361, 16'hFCEF};
        for (int i = 0; i < 6; i++)
            mdl.mem[8'h28 + i] = raw[i/2][8*(i%2) +: 8];
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk("scl_oe_n", 8'h01, {7'h00, aux_scl_oe_n_q});
        t_write;
        t_read;
        t_pass;
        complete_run;
    end
endmodule
